// ==== hls_hub_link_regs.sv ====
// Purpose: Software-visible hub link status and control register bank.
// Assumes: One core clock; window accesses are dword-aligned with byte lanes;
//          link-side inputs come from logic on core_clk.
// Notes:   Ordinary reset spares the sticky error registers; cold_reset clears all.
// Operation
// - Channel-one negotiation-pending flag, read-only bit 1, resets to 0.
// - Capability bits 17:15 deep-sleep exit latency, default 010b, write-once.
// - Capability bits 14:12 standby exit latency, default 010b, write-once.
// - Capability bits 11:10 read-only 11b: standby state supported.
// - Capability bits 9:4 read-only maximum lane count, four lanes.
// - Capability bits 3:0 read-only maximum signal rate 1h.
// - Control bit 7 requests longer resync sequences on state exits.
// - Control bits 1:0: 00 off, 01 standby allowed, others reserved.
// - Status bits 9:4 report agreed lane count, four lanes read 000100b.
// - Status bits 3:0 report signal rate 1h; register resets to 0001h.
// - Error status holds one bit per source at fixed positions.
// - Error bit set by hardware, cleared by writing one, resets to zero.
// - One mask bit per error status bit, same position.
// - Masked errors are logged but not reported; unmasked errors are reported when their status bit is clear.
// - Mask bits read-write, default zero; unused bits read zero.
`timescale 1ns/1ns
`default_nettype none
module hls_hub_link_regs
    import hls_pkg::*;
#(
    parameter int N_ERR = UE_COUNT
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             cold_reset,
    input  wire logic             reg_req,
    input  wire logic             reg_write,
    input  wire logic [11:0]      reg_addr,
    input  wire logic [3:0]       reg_byte_en,
    input  wire logic [31:0]      reg_wdata,
    output var  logic [31:0]      reg_rdata,
    output var  logic             reg_ack,
    input  wire logic             vc1_negotiating,
    input  wire logic [5:0]       link_lane_count,
    input  wire logic [N_ERR-1:0] ue_event,
    output var  logic [2:0]       deep_sleep_exit_latency,
    output var  logic [2:0]       standby_exit_latency,
    output var  logic             long_resync,
    output var  logic [1:0]       power_state_control,
    output var  logic             standby_entry_enable,
    output var  logic             error_report
);
    hls_wr_if wr ();

    logic        warm;
    logic        wr_stb;
    logic [31:0] lane_bits;
    logic        negotiation_pending;
    logic [5:0]  agreed_lane_count;
    logic [31:0] ue_status_word;
    logic [31:0] ue_mask_word;
    logic [31:0] next_rdata;

    initial begin
        if (N_ERR != UE_COUNT) begin
            $error("hls_hub_link_regs: error source count is fixed by the layout");
        end
    end

    // The sticky error bits are the only state that the warm reset spares
    assign warm   = reset || cold_reset;
    assign wr_stb = reg_req && reg_write;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign lane_bits[8*b +: 8] = {8{reg_byte_en[b]}};
    end

    assign wr.wr_bits      = lane_bits;
    assign wr.wr_data      = reg_wdata;
    assign wr.cap_wr       = wr_stb && dword_hit(reg_addr, OFF_LINK_CAPABILITIES);
    assign wr.ue_status_wr = wr_stb && dword_hit(reg_addr, OFF_UE_STATUS);
    assign wr.ue_mask_wr   = wr_stb && dword_hit(reg_addr, OFF_UE_MASK);

    // Write-once exit latency fields
    hls_write_once #(
        .LSB (DEEP_SLEEP_EXIT_LSB),
        .W   (EXIT_LATENCY_W),
        .RST (EXIT_LATENCY_RST)
    ) u_deep_sleep_exit (
        .core_clk (core_clk),
        .reset    (warm),
        .bus      (wr.sink),
        .field    (deep_sleep_exit_latency)
    );

    hls_write_once #(
        .LSB (STANDBY_EXIT_LSB),
        .W   (EXIT_LATENCY_W),
        .RST (EXIT_LATENCY_RST)
    ) u_standby_exit (
        .core_clk (core_clk),
        .reset    (warm),
        .bus      (wr.sink),
        .field    (standby_exit_latency)
    );

    hls_error_log #(
        .N (N_ERR)
    ) u_error_log (
        .core_clk     (core_clk),
        .cold_reset   (cold_reset),
        .reset        (reset),
        .bus          (wr.sink),
        .ue_event     (ue_event),
        .status_word  (ue_status_word),
        .mask_word    (ue_mask_word),
        .error_report (error_report)
    );

    // Link control: only byte lane 0 holds implemented bits
    always_ff @(posedge core_clk) begin
        if (warm) begin
            long_resync         <= LINK_CONTROL_RST[LONG_RESYNC_BIT];
            power_state_control <= LINK_CONTROL_RST[POWER_STATE_CONTROL_LSB +: 2];
        end else if (wr_stb && dword_hit(reg_addr, OFF_LINK_CONTROL) && reg_byte_en[0]) begin
            long_resync         <= reg_wdata[LONG_RESYNC_BIT];
            power_state_control <= reg_wdata[POWER_STATE_CONTROL_LSB +: 2];
        end
    end

    // Reserved codes are stored for readback but never enable standby entry
    always_ff @(posedge core_clk) begin
        if (warm) begin
            standby_entry_enable <= 1'b0;
        end else begin
            standby_entry_enable <= (power_state_control == PSC_STANDBY_ON);
        end
    end

    // Link-side status, sampled every cycle once out of reset
    always_ff @(posedge core_clk) begin
        if (warm) begin
            negotiation_pending <= VC1_RESOURCE_STATUS_RST[NEGOTIATION_PENDING_BIT];
            agreed_lane_count   <= LINK_STATUS_RST[AGREED_LANE_COUNT_LSB +: 6];
        end else begin
            negotiation_pending <= vc1_negotiating;
            agreed_lane_count   <= link_lane_count;
        end
    end

    // Read mux; unmapped dwords and reserved bits read zero
    always_comb begin
        next_rdata = '0;
        if (dword_hit(reg_addr, OFF_VC1_RESOURCE_STATUS)) begin
            next_rdata[16 + NEGOTIATION_PENDING_BIT] = negotiation_pending;
        end else if (dword_hit(reg_addr, OFF_LINK_CAPABILITIES)) begin
            next_rdata[DEEP_SLEEP_EXIT_LSB +: 3]     = deep_sleep_exit_latency;
            next_rdata[STANDBY_EXIT_LSB +: 3]        = standby_exit_latency;
            next_rdata[POWER_STATE_SUPPORT_LSB +: 2] = POWER_STATE_SUPPORT;
            next_rdata[MAX_LANE_COUNT_LSB +: 6]      = MAX_LANE_COUNT;
            next_rdata[MAX_SIGNAL_RATE_LSB +: 4]     = MAX_SIGNAL_RATE;
        end else if (dword_hit(reg_addr, OFF_LINK_CONTROL)) begin
            next_rdata[LONG_RESYNC_BIT]                   = long_resync;
            next_rdata[POWER_STATE_CONTROL_LSB +: 2]      = power_state_control;
            next_rdata[16 + AGREED_LANE_COUNT_LSB +: 6]   = agreed_lane_count;
            next_rdata[16 + CURRENT_SIGNAL_RATE_LSB +: 4] = CURRENT_SIGNAL_RATE;
        end else if (dword_hit(reg_addr, OFF_UE_STATUS)) begin
            next_rdata = ue_status_word & UE_IMPL_MASK;
        end else if (dword_hit(reg_addr, OFF_UE_MASK)) begin
            next_rdata = ue_mask_word & UE_IMPL_MASK;
        end
        next_rdata = next_rdata & lane_bits;
    end

    // One answer per request, one cycle later
    always_ff @(posedge core_clk) begin
        if (warm) begin
            reg_ack   <= 1'b0;
            reg_rdata <= '0;
        end else begin
            reg_ack   <= reg_req;
            reg_rdata <= (reg_req && !reg_write) ? next_rdata : '0;
        end
    end
endmodule
`default_nettype wire

// ==== hls_pkg.sv ====
// Purpose: Shared constants for the hub link status and control register bank.
// Assumes: Byte offsets inside the 4 KB hub_link_window; dword-wide access with byte lanes.
// Notes:   Every offset, field position and reset value is named here once.
`default_nettype none
package hls_pkg;

    // Register byte offsets in the window
    localparam logic [11:0] OFF_VC1_RESOURCE_STATUS = 12'h026;
    localparam logic [11:0] OFF_LINK_CAPABILITIES   = 12'h084;
    localparam logic [11:0] OFF_LINK_CONTROL        = 12'h088;
    localparam logic [11:0] OFF_LINK_STATUS         = 12'h08A;
    localparam logic [11:0] OFF_UE_STATUS           = 12'h1C4;
    localparam logic [11:0] OFF_UE_MASK             = 12'h1C8;

    // Reset values
    localparam logic [15:0] VC1_RESOURCE_STATUS_RST = 16'h0000;
    localparam logic [31:0] LINK_CAPABILITIES_RST   = 32'h0001_2C41;
    localparam logic [15:0] LINK_CONTROL_RST        = 16'h0000;
    localparam logic [15:0] LINK_STATUS_RST         = 16'h0001;
    localparam logic [31:0] UE_STATUS_RST           = 32'h0000_0000;
    localparam logic [31:0] UE_MASK_RST             = 32'h0000_0000;

    // vc1_resource_status fields
    localparam int NEGOTIATION_PENDING_BIT = 1;

    // link_capabilities fields
    localparam int DEEP_SLEEP_EXIT_LSB    = 15;
    localparam int STANDBY_EXIT_LSB       = 12;
    localparam int EXIT_LATENCY_W         = 3;
    localparam int POWER_STATE_SUPPORT_LSB = 10;
    localparam int MAX_LANE_COUNT_LSB     = 4;
    localparam int MAX_SIGNAL_RATE_LSB    = 0;
    localparam logic [2:0] EXIT_LATENCY_RST    = 3'h2;
    localparam logic [1:0] POWER_STATE_SUPPORT = 2'h3;
    localparam logic [5:0] MAX_LANE_COUNT      = 6'h04;
    localparam logic [3:0] MAX_SIGNAL_RATE     = 4'h1;

    // link_control fields
    localparam int LONG_RESYNC_BIT         = 7;
    localparam int POWER_STATE_CONTROL_LSB = 0;
    localparam logic [1:0] PSC_DISABLED    = 2'h0;
    localparam logic [1:0] PSC_STANDBY_ON  = 2'h1;

    // link_status fields
    localparam int AGREED_LANE_COUNT_LSB   = 4;
    localparam int CURRENT_SIGNAL_RATE_LSB = 0;
    localparam logic [3:0] CURRENT_SIGNAL_RATE = 4'h1;

    // Uncorrectable error sources and their bit positions
    localparam int UE_COUNT = 6;
    localparam int UE_POS [UE_COUNT] = '{20, 18, 17, 16, 14, 4};
    localparam logic [31:0] UE_IMPL_MASK = 32'h0017_4010;

    // True when a byte address falls in the dword holding the given register
    function automatic logic dword_hit(input logic [11:0] addr, input logic [11:0] off);
        return addr[11:2] == off[11:2];
    endfunction

endpackage
`default_nettype wire

// ==== hls_wr_if.sv ====
// Purpose: Carries one register write from the bank's decoder to its field holders.
// Assumes: Single core clock; strobes last one cycle.
// Notes:   Byte lanes are already expanded into per-bit enables.
`timescale 1ns/1ns
`default_nettype none
interface hls_wr_if;
    logic        cap_wr;
    logic        ue_status_wr;
    logic        ue_mask_wr;
    logic [31:0] wr_bits;
    logic [31:0] wr_data;

    modport source (output cap_wr, output ue_status_wr, output ue_mask_wr,
                    output wr_bits, output wr_data);
    modport sink   (input cap_wr, input ue_status_wr, input ue_mask_wr,
                    input wr_bits, input wr_data);
endinterface
`default_nettype wire

// ==== hls_write_once.sv ====
// Purpose: One write-once field of link_capabilities.
// Assumes: Writes arrive as one-cycle strobes with per-bit enables.
// Notes:   Any write touching at least one bit of the field spends its single chance.
`timescale 1ns/1ns
`default_nettype none
module hls_write_once
    import hls_pkg::*;
#(
    parameter int             LSB = 12,
    parameter int             W   = 3,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    hls_wr_if.sink            bus,
    output var  logic [W-1:0] field
);
    logic           locked;
    logic [W-1:0]   bits;

    initial begin
        if (LSB < 0 || LSB + W > 32) begin
            $error("hls_write_once: field outside the register");
        end
    end

    assign bits = bus.wr_bits[LSB +: W];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            field  <= RST;
            locked <= 1'b0;
        end else if (bus.cap_wr && (|bits) && !locked) begin
            field  <= (field & ~bits) | (bus.wr_data[LSB +: W] & bits);
            locked <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== hls_error_log.sv ====
// Purpose: Uncorrectable error status and mask bits with the error-report pulse.
// Assumes: Error events are one-cycle pulses on core_clk from the link logic.
// Notes:   Status and mask are sticky: only the power-on reset clears them.
`timescale 1ns/1ns
`default_nettype none
module hls_error_log
    import hls_pkg::*;
#(
    parameter int N = UE_COUNT
) (
    input  wire logic         core_clk,
    input  wire logic         cold_reset,
    input  wire logic         reset,
    hls_wr_if.sink            bus,
    input  wire logic [N-1:0] ue_event,
    output var  logic [31:0]  status_word,
    output var  logic [31:0]  mask_word,
    output var  logic         error_report
);
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic [N-1:0] fresh;

    initial begin
        if (N != UE_COUNT) begin
            $error("hls_error_log: source count must match the position table");
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_src
        localparam int P = UE_POS[i];

        // Set wins over a same-cycle write-one-to-clear
        always_ff @(posedge core_clk) begin
            if (cold_reset) begin
                status[i] <= 1'b0;
            end else if (ue_event[i]) begin
                status[i] <= 1'b1;
            end else if (bus.ue_status_wr && bus.wr_bits[P] && bus.wr_data[P]) begin
                status[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (cold_reset) begin
                mask[i] <= 1'b0;
            end else if (bus.ue_mask_wr && bus.wr_bits[P]) begin
                mask[i] <= bus.wr_data[P];
            end
        end

        // Masked sources still log but are never reported
        assign fresh[i] = ue_event[i] && !status[i] && !mask[i];
    end

    always_comb begin
        status_word = '0;
        mask_word   = '0;
        for (int k = 0; k < N; k++) begin
            status_word[UE_POS[k]] = status[k];
            mask_word[UE_POS[k]]   = mask[k];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || cold_reset) begin
            error_report <= 1'b0;
        end else begin
            error_report <= |fresh;
        end
    end
endmodule
`default_nettype wire

// ==== hls_hub_link_regs_monitor.sv ====
// Purpose: Port-level checks on the hub link register bank.
// Assumes: One core clock; both resets synchronous, active high.
// Notes:   Sees ports only; link-side inputs are taken as given.
`timescale 1ns/1ns
`default_nettype none
module hls_hub_link_regs_monitor
    import hls_pkg::*;
#(
    parameter int N_ERR = UE_COUNT
) (
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             cold_reset,
    input wire logic             reg_req,
    input wire logic             reg_write,
    input wire logic [11:0]      reg_addr,
    input wire logic [3:0]       reg_byte_en,
    input wire logic [31:0]      reg_wdata,
    input wire logic [31:0]      reg_rdata,
    input wire logic             reg_ack,
    input wire logic             vc1_negotiating,
    input wire logic [5:0]       link_lane_count,
    input wire logic [N_ERR-1:0] ue_event,
    input wire logic [2:0]       deep_sleep_exit_latency,
    input wire logic [2:0]       standby_exit_latency,
    input wire logic             long_resync,
    input wire logic [1:0]       power_state_control,
    input wire logic             standby_entry_enable,
    input wire logic             error_report
);
    logic rd_take;
    assign rd_take = reg_req && !reg_write && reg_byte_en == 4'hF;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset || cold_reset);
    cap_fixed_bits_a: assert property (
        rd_take && dword_hit(reg_addr, OFF_LINK_CAPABILITIES) |=>
        reg_rdata[11:0] == 12'hC41 && reg_rdata[31:18] == 14'h0000)
        else $error("capability read-only bits wrong");
    status_rate_fixed_a: assert property (
        rd_take && dword_hit(reg_addr, OFF_LINK_STATUS) |=>
        reg_rdata[19:16] == 4'h1 && reg_rdata[31:26] == 6'h00)
        else $error("link status rate bits wrong");
    vc1_pending_only_a: assert property (
        rd_take && dword_hit(reg_addr, OFF_VC1_RESOURCE_STATUS) |=>
        reg_rdata[31:18] == 14'h0000 && !reg_rdata[16])
        else $error("channel status reserved bits set");
    error_unused_zero_a: assert property (
        rd_take && (dword_hit(reg_addr, OFF_UE_STATUS) || dword_hit(reg_addr, OFF_UE_MASK))
        |=> (reg_rdata & ~UE_IMPL_MASK) == 32'h0000_0000)
        else $error("unused error bit reads one");
    control_write_a: assert property (
        reg_req && reg_write && reg_byte_en[0] && dword_hit(reg_addr, OFF_LINK_CONTROL) |=>
        long_resync == $past(reg_wdata[7]) && power_state_control == $past(reg_wdata[1:0]))
        else $error("control write not applied");
    standby_gate_a: assert property (
        !$past(reset) && !$past(cold_reset) |->
        standby_entry_enable == ($past(power_state_control) == PSC_STANDBY_ON))
        else $error("standby entry enable does not follow code 01");
    report_has_cause_a: assert property (error_report |-> $past(|ue_event))
        else $error("error report without an error event");
    latency_reset_value_a: assert property (
        $fell(reset) |-> deep_sleep_exit_latency == 3'h2 && standby_exit_latency == 3'h2)
        else $error("exit latencies not at default after reset");
endmodule
bind hls_hub_link_regs hls_hub_link_regs_monitor #(.N_ERR(N_ERR)) u_hls_hub_link_regs_monitor (
    .core_clk(core_clk), .reset(reset), .cold_reset(cold_reset), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .vc1_negotiating(vc1_negotiating), .link_lane_count(link_lane_count),
    .ue_event(ue_event), .deep_sleep_exit_latency(deep_sleep_exit_latency),
    .standby_exit_latency(standby_exit_latency), .long_resync(long_resync),
    .power_state_control(power_state_control), .standby_entry_enable(standby_entry_enable),
    .error_report(error_report));
`default_nettype wire

// ==== hls_link_partner.sv ====
// Purpose: Behavioural far end of the hub link feeding status and errors.
// Assumes: Driven on core_clk; bench requests last one cycle.
// Notes:   Negotiation length is a plain parameter, not a link figure.
`timescale 1ns/1ns
`default_nettype none
module hls_link_partner
    import hls_pkg::*;
#(
    parameter int N_ERR      = UE_COUNT,
    parameter int NEG_CYCLES = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             start_neg,
    input  wire logic [N_ERR-1:0] err_req,
    output var  logic             vc1_negotiating,
    output var  logic [5:0]       link_lane_count,
    output var  logic [N_ERR-1:0] ue_event
);
    int left;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vc1_negotiating <= 1'b0;
            link_lane_count <= 6'h00;
            left            <= 0;
        end else if (start_neg) begin
            vc1_negotiating <= 1'b1;
            link_lane_count <= 6'h00;
            left            <= NEG_CYCLES;
        end else if (left == 1) begin
            vc1_negotiating <= 1'b0;
            link_lane_count <= 6'h04;
            left            <= 0;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
    // Single-cycle pulses: a held request would count as repeated errors
    always_ff @(posedge core_clk) begin
        ue_event <= reset ? '0 : err_req;
    end
endmodule
`default_nettype wire

// ==== hls_hub_link_regs_bench.sv ====
// Purpose: Self-checking bench for the hub link register bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Each access is followed by one idle cycle.
`timescale 1ns/1ns
`default_nettype none
module hls_hub_link_regs_bench import hls_pkg::*;;
    logic        core_clk;
    logic        reset;
    logic        cold_reset;
    logic        link_reset;
    logic        reg_req     = 1'b0;
    logic        reg_write   = 1'b0;
    logic [11:0] reg_addr    = 12'h000;
    logic [3:0]  reg_byte_en = 4'h0;
    logic [31:0] reg_wdata   = 32'h0000_0000;
    logic        start_neg   = 1'b0;
    logic [5:0]  err_req     = 6'h00;
    logic [31:0] reg_rdata, rd, ue_exp = 32'h0000_0000;
    logic        reg_ack, vc1_negotiating, long_resync, standby_entry_enable, error_report;
    logic [5:0]  link_lane_count, ue_event;
    logic [2:0]  deep_sleep_exit_latency, standby_exit_latency;
    logic [1:0]  power_state_control;
    int          miscompares = 0, check_count = 0, cycles = 0;
    logic [11:0] ra [6] = '{OFF_VC1_RESOURCE_STATUS, OFF_LINK_CAPABILITIES,
                            OFF_LINK_CONTROL, OFF_UE_STATUS, OFF_UE_MASK, 12'h100};
    logic [31:0] rx [6] = '{32'h0000_0000, 32'h0001_2C41, 32'h0001_0000,
                            32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    assign link_reset = reset | cold_reset;
    hls_hub_link_regs u_hls_hub_link_regs (.core_clk(core_clk), .reset(reset),
        .cold_reset(cold_reset), .reg_req(reg_req), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .vc1_negotiating(vc1_negotiating),
        .link_lane_count(link_lane_count), .ue_event(ue_event),
        .deep_sleep_exit_latency(deep_sleep_exit_latency),
        .standby_exit_latency(standby_exit_latency), .long_resync(long_resync),
        .power_state_control(power_state_control),
        .standby_entry_enable(standby_entry_enable), .error_report(error_report));
    hls_link_partner u_hls_link_partner (.core_clk(core_clk), .reset(link_reset),
        .start_neg(start_neg), .err_req(err_req), .vc1_negotiating(vc1_negotiating),
        .link_lane_count(link_lane_count), .ue_event(ue_event));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        reg_req     = 1'b1;
        reg_write   = w;
        reg_addr    = a;
        reg_byte_en = be;
        reg_wdata   = d;
        step();
        reg_req = 1'b0;
        rd      = reg_rdata;
        chk({31'h0, reg_ack}, 32'h1);
        step();
    endtask
    task automatic rst(input logic w, input logic c);
        reset      = w;
        cold_reset = c;
        repeat (3) @(posedge core_clk);
        #1;
        reset      = 1'b0;
        cold_reset = 1'b0;
    endtask
    // Event reaches the bank one edge after the request; error_report follows one edge later
    task automatic fire(input int i, input logic rep);
        err_req = 6'h01 << i;
        step();
        err_req = 6'h00;
        step();
        chk({31'h0, error_report}, {31'h0, rep});
        step();
    endtask
    initial begin
        rst(1'b1, 1'b1);
        for (int k = 0; k < 6; k++) begin
            acc(1'b0, ra[k], 4'hF, 32'h0);
            chk(rd, rx[k]);
        end
        start_neg = 1'b1;
        step();
        start_neg = 1'b0;
        step();
        acc(1'b0, OFF_VC1_RESOURCE_STATUS, 4'hC, 32'h0);
        chk(rd, 32'h0002_0000);
        repeat (10) step();
        acc(1'b0, OFF_VC1_RESOURCE_STATUS, 4'hC, 32'h0);
        chk(rd, 32'h0000_0000);
        acc(1'b1, OFF_LINK_CAPABILITIES, 4'hF, 32'hFFFF_FFFF);
        chk({26'h0, deep_sleep_exit_latency, standby_exit_latency}, 32'h3F);
        acc(1'b1, OFF_LINK_CAPABILITIES, 4'hF, 32'h0);
        acc(1'b0, OFF_LINK_CAPABILITIES, 4'hF, 32'h0);
        chk(rd, 32'h0003_FC41);
        rst(1'b1, 1'b0);
        acc(1'b0, OFF_LINK_CAPABILITIES, 4'hF, 32'h0);
        chk(rd, 32'h0001_2C41);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, OFF_LINK_CONTROL, 4'h1, {24'h0, k[0], 5'h0, k[1:0]});
            chk({30'h0, power_state_control}, 32'(k));
            chk({31'h0, long_resync}, {31'h0, k[0]});
            chk({31'h0, standby_entry_enable}, {31'h0, k == 1});
        end
        // The warm reset dropped the link, so renegotiate before reading the width
        start_neg = 1'b1;
        step();
        start_neg = 1'b0;
        repeat (10) step();
        acc(1'b1, OFF_LINK_STATUS, 4'hC, 32'hFFFF_FFFF);
        acc(1'b0, OFF_LINK_CONTROL, 4'hF, 32'h0);
        chk(rd, 32'h0041_0083);
        for (int k = 0; k < UE_COUNT; k++) begin
            fire(k, 1'b1);
            ue_exp = ue_exp | (32'h1 << UE_POS[k]);
            acc(1'b0, OFF_UE_STATUS, 4'hF, 32'h0);
            chk(rd, ue_exp);
        end
        fire(0, 1'b0);
        acc(1'b1, OFF_UE_STATUS, 4'hF, 32'h0);
        rst(1'b1, 1'b0);
        acc(1'b0, OFF_UE_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h0017_4010);
        acc(1'b1, OFF_UE_STATUS, 4'hF, 32'h0010_0000);
        acc(1'b0, OFF_UE_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h0007_4010);
        acc(1'b1, OFF_UE_MASK, 4'hF, 32'hFFFF_FFFF);
        fire(0, 1'b0);
        rst(1'b1, 1'b0);
        acc(1'b0, OFF_UE_MASK, 4'hF, 32'h0);
        chk(rd, 32'h0017_4010);
        rst(1'b0, 1'b1);
        acc(1'b0, OFF_UE_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h0000_0000);
        acc(1'b0, OFF_UE_MASK, 4'hF, 32'h0);
        chk(rd, 32'h0000_0000);
        conclude();
    end
endmodule
`default_nettype wire
